// [core/amx_defines.svh]
// shared constants of the analog mux switch control block
`ifndef AMX_DEFINES_SVH
`define AMX_DEFINES_SVH

// control word field positions
`define AMX_DIS_BIT 3
`define AMX_BANK_BIT 2
`define AMX_HI_BIT 1
`define AMX_LO_BIT 0

// widths
`define AMX_WORD_W 4
`define AMX_SW_W 8
`define AMX_PIN_W 9

// reset values and decode constants
`define AMX_CTRL_RST 4'h8
`define AMX_SHIFT_RST 4'h0
`define AMX_SW_OFF 8'h00
`define AMX_ONE_HOT 8'h01
`define AMX_BANK_OFS 3'h4

// reset values of the clock-domain pin synchroniser
// order: ser, le_n, clr_n, bank, hi, lo, en, pair, cs_n
`define AMX_PIN_RST 9'h0C1

`endif

// [core/amx_pkg.sv]
// types of the analog mux switch control block
package amx_pkg;

  typedef enum logic {
    AMX_MODE_PAR,
    AMX_MODE_SER
  } amx_mode_t;

  // latched control word, disable in the msb
  typedef struct packed {
    logic dis;
    logic bank;
    logic hi;
    logic lo;
  } amx_ctrl_t;

  // synchronised copy of the control pins
  typedef struct packed {
    logic ser;
    logic le_n;
    logic clr_n;
    logic bank;
    logic hi;
    logic lo;
    logic en;
    logic pair;
    logic cs_n;
  } amx_pins_t;

endpackage : amx_pkg

// [core/amx_sync.sv]
// two flip-flop synchroniser with a per-bit reset value
`timescale 1ns/1ps
`default_nettype none

module amx_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // data
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);

  logic [W-1:0] meta_reg;

  // the first stage feeds only the second
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      meta_reg <= RST_VAL;
      q_o <= RST_VAL;
    end else begin
      meta_reg <= d_i;
      q_o <= meta_reg;
    end
  end

endmodule : amx_sync

`default_nettype wire

// [core/amx_ctrl.sv]
// control logic of a dual 4-channel analog multiplexer
//
// Contract
// - parallel latch transparent when latch_open_n low
// - clear low opens all switches, clears latches
// - serial mode ignores parallel control pins
// - single mode: bank bit picks bank, addr channel
// - pair mode closes channel k+1 and k+5
// - pair select never latched, acts directly
// - chip select low: each clock shifts one bit; code skips the first two sclk rises after reset, clear or serial mode entry
// - serial out is fourth stage output
// - chip select rise copies shift register to latches
// - word lsb first, disable bit last
// - latched disable one forces all switches off
// - serial clear also empties shift register
// - parallel mode puts serial out high-z
// - power-up: address zero, disabled, switches off
// - transfer only on chip select rising edge
`timescale 1ns/1ps
`default_nettype none

`include "amx_defines.svh"

module amx_ctrl
  import amx_pkg::*;
(
  // system clock and power-on reset
  input wire logic clk_i,
  input wire logic rst_i,
  // serial link, clocked by the master
  input wire logic sclk_i,
  input wire logic cs_n_i,
  input wire logic serial_in_i,
  output logic serial_out_o,
  output logic serial_out_oe_n_o,
  // mode and clear pins
  input wire logic serial_parallel_select_i,
  input wire logic clear_all_n_i,
  input wire logic dual_pair_select_i,
  // parallel control pins
  input wire logic latch_open_n_i,
  input wire logic bank_select_bit_i,
  input wire logic channel_addr_hi_i,
  input wire logic channel_addr_lo_i,
  input wire logic enable_i,
  // switch states, bit n closes channel_terminal_(n+1)
  output logic [`AMX_SW_W-1:0] switch_on_o
);

  // ---------------------------------------------------------------
  // link domain
  // ---------------------------------------------------------------

  logic link_clr;
  logic link_ser;
  logic shift_en;
  logic [`AMX_WORD_W-1:0] sh_reg;

  // clear is asynchronous here because the link clock may be stopped
  assign link_clr = rst_i | ~clear_all_n_i;

  amx_sync #(
    .W(1),
    .RST_VAL(1'h0)
  ) u_link_mode_sync (
    .clk_i(sclk_i),
    .rst_i(link_clr),
    .d_i(serial_parallel_select_i),
    .q_o(link_ser)
  );

  assign shift_en = link_ser & ~cs_n_i;

  always_ff @(posedge sclk_i or posedge link_clr) begin
    if (link_clr) begin
      sh_reg <= `AMX_SHIFT_RST;
    end else if (shift_en) begin
      sh_reg <= {sh_reg[`AMX_WORD_W-2:0], serial_in_i};
    end
  end

  // fourth stage drives the cascade output
  assign serial_out_o = sh_reg[`AMX_WORD_W-1];

  // ---------------------------------------------------------------
  // system domain
  // ---------------------------------------------------------------

  amx_pins_t pins_q;
  amx_mode_t mode_reg;
  amx_mode_t mode_next;
  amx_ctrl_t ctrl_reg;
  amx_ctrl_t ctrl_next;
  amx_ctrl_t xfer_word;
  amx_ctrl_t par_word;
  logic cs_d_reg;
  logic cs_rise;
  logic [`AMX_SW_W-1:0] sw_next;
  logic [2:0] sel_idx;
  logic [2:0] pair_idx;

  amx_sync #(
    .W(`AMX_PIN_W),
    .RST_VAL(`AMX_PIN_RST)
  ) u_pin_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .d_i({serial_parallel_select_i, latch_open_n_i, clear_all_n_i,
          bank_select_bit_i, channel_addr_hi_i, channel_addr_lo_i,
          enable_i, dual_pair_select_i, cs_n_i}),
    .q_o(pins_q)
  );

  assign mode_next = pins_q.ser ? AMX_MODE_SER : AMX_MODE_PAR;

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      mode_reg <= AMX_MODE_PAR;
    end else begin
      mode_reg <= mode_next;
    end
  end

  // rising edge of the synchronised select
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      cs_d_reg <= 1'h1;
    end else begin
      cs_d_reg <= pins_q.cs_n;
    end
  end

  assign cs_rise = pins_q.cs_n & ~cs_d_reg;

  // first bit sent has travelled furthest
  // the word is quasi-static: sclk is ignored once select is high,
  // so the master must keep select high for at least three clk cycles
  assign xfer_word.lo = sh_reg[3];
  assign xfer_word.hi = sh_reg[2];
  assign xfer_word.bank = sh_reg[1];
  assign xfer_word.dis = sh_reg[0];

  assign par_word.dis = ~pins_q.en;
  assign par_word.bank = pins_q.bank;
  assign par_word.hi = pins_q.hi;
  assign par_word.lo = pins_q.lo;

  always_comb begin
    ctrl_next = ctrl_reg;
    if (!pins_q.clr_n) begin
      ctrl_next = amx_ctrl_t'(`AMX_CTRL_RST);
    end else begin
      // live mode: the mode pin and the parallel pins pass the synchroniser
      // together, so a mode change never lets a parallel word slip in
      case (mode_next)
        AMX_MODE_PAR: begin
          if (!pins_q.le_n) begin
            ctrl_next = par_word;
          end
        end
        AMX_MODE_SER: begin
          // parallel pins are not looked at
          if (cs_rise) begin
            ctrl_next = xfer_word;
          end
        end
        default: begin
          ctrl_next = ctrl_reg;
        end
      endcase
    end
  end

  // power-up word equals the clear word
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      ctrl_reg <= amx_ctrl_t'(`AMX_CTRL_RST);
    end else begin
      ctrl_reg <= ctrl_next;
    end
  end

  assign sel_idx = {ctrl_reg.bank, ctrl_reg.hi, ctrl_reg.lo};
  assign pair_idx = {1'h0, ctrl_reg.hi, ctrl_reg.lo};

  always_comb begin
    sw_next = `AMX_SW_OFF;
    if (!pins_q.clr_n || ctrl_reg.dis) begin
      sw_next = `AMX_SW_OFF;
    // pair pin taken live, not from the latch
    // both banks at once, bank bit ignored
    end else if (pins_q.pair) begin
      sw_next = (`AMX_ONE_HOT << pair_idx) | (`AMX_ONE_HOT << (pair_idx + `AMX_BANK_OFS));
    end else begin
      sw_next = `AMX_ONE_HOT << sel_idx;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      switch_on_o <= `AMX_SW_OFF;
    end else begin
      switch_on_o <= sw_next;
    end
  end

  // cascade output floats in parallel mode
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      serial_out_oe_n_o <= 1'h1;
    end else begin
      serial_out_oe_n_o <= (mode_next != AMX_MODE_SER);
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------

  a_par_hold: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (mode_next == AMX_MODE_PAR && pins_q.le_n && pins_q.clr_n) |=> $stable(ctrl_reg)
  ) else $error("parallel latch changed while holding");

  a_par_open: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (mode_next == AMX_MODE_PAR && !pins_q.le_n && pins_q.clr_n) |=> (ctrl_reg == $past(par_word))
  ) else $error("parallel latch not transparent");

  a_clear_all_off: assert property (
    @(posedge clk_i) disable iff (rst_i)
    !pins_q.clr_n |=> (switch_on_o == `AMX_SW_OFF && ctrl_reg == amx_ctrl_t'(`AMX_CTRL_RST))
  ) else $error("clear did not open switches and clear latches");

  a_ser_ignore_par: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (mode_next == AMX_MODE_SER && pins_q.clr_n && !cs_rise) |=> $stable(ctrl_reg)
  ) else $error("serial mode word changed without transfer");

  a_single_decode: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (pins_q.clr_n && !ctrl_reg.dis && !pins_q.pair) |=> (switch_on_o == (`AMX_ONE_HOT << $past(sel_idx)))
  ) else $error("single mode decode wrong");

  a_pair_decode: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (pins_q.clr_n && !ctrl_reg.dis && pins_q.pair) |=>
      (switch_on_o == ((`AMX_ONE_HOT << $past(pair_idx)) | (`AMX_ONE_HOT << ($past(pair_idx) + `AMX_BANK_OFS))))
  ) else $error("pair mode decode wrong");

  a_pair_live: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (pins_q.clr_n && !ctrl_reg.dis && $stable(ctrl_reg) && $changed(pins_q.pair)) |=>
      (switch_on_o != $past(switch_on_o))
  ) else $error("pair select change did not reach switches");

  a_shift_in: assert property (
    @(posedge sclk_i) disable iff (link_clr)
    shift_en |=> (sh_reg[0] == $past(serial_in_i))
  ) else $error("serial bit not shifted in");

  a_dout_delay: assert property (
    @(posedge sclk_i) disable iff (link_clr)
    shift_en [*4] |=> (serial_out_o == $past(serial_in_i, 4))
  ) else $error("serial out not delayed by four clocks");

  a_xfer_word: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (mode_next == AMX_MODE_SER && pins_q.clr_n && cs_rise) |=> (ctrl_reg == $past(xfer_word))
  ) else $error("shift register not transferred on select rise");

  a_xfer_order: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (mode_next == AMX_MODE_SER && pins_q.clr_n && cs_rise) |=>
      (ctrl_reg.lo == $past(sh_reg[3]) && ctrl_reg.dis == $past(sh_reg[0]))
  ) else $error("serial word bit order wrong");

  a_disable_off: assert property (
    @(posedge clk_i) disable iff (rst_i)
    ctrl_reg.dis |=> (switch_on_o == `AMX_SW_OFF)
  ) else $error("disable bit did not open switches");

  a_clear_shift: assert property (
    @(posedge clk_i) disable iff (rst_i)
    !clear_all_n_i |-> (sh_reg == `AMX_SHIFT_RST)
  ) else $error("clear did not empty shift register");

  a_par_hiz: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (mode_reg == AMX_MODE_PAR && mode_next == AMX_MODE_PAR) |=> serial_out_oe_n_o
  ) else $error("serial out driven in parallel mode");

  a_ser_drive: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (mode_next == AMX_MODE_SER) |=> !serial_out_oe_n_o
  ) else $error("serial out not driven in serial mode");

  a_edge_only: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (mode_reg == AMX_MODE_SER && $changed(ctrl_reg) && $past(pins_q.clr_n)) |-> $past(cs_rise)
  ) else $error("serial transfer without select rise");

  a_idle_hold: assert property (
    @(posedge sclk_i) disable iff (link_clr)
    cs_n_i |=> $stable(sh_reg)
  ) else $error("shift register moved while unselected");

  a_por_state: assert property (
    @(posedge clk_i)
    rst_i |=> (ctrl_reg == amx_ctrl_t'(`AMX_CTRL_RST) && switch_on_o == `AMX_SW_OFF && serial_out_oe_n_o)
  ) else $error("reset state not disabled with switches off");

  a_en_off: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (mode_next == AMX_MODE_PAR && !pins_q.le_n && pins_q.clr_n && !pins_q.en) |=> ##1 (switch_on_o == `AMX_SW_OFF)
  ) else $error("inactive enable left a switch closed");

  a_bank_split: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (pins_q.clr_n && !ctrl_reg.dis && !pins_q.pair) |=> ($onehot(switch_on_o) && ((switch_on_o[7:4] != 4'h0) == $past(ctrl_reg.bank)))
  ) else $error("single mode closed wrong bank or several switches");

  a_pair_both: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (pins_q.clr_n && !ctrl_reg.dis && pins_q.pair) |=> ($onehot(switch_on_o[3:0]) && switch_on_o[3:0] == switch_on_o[7:4])
  ) else $error("pair mode did not close one switch in each bank");

  a_dis_word: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (mode_next == AMX_MODE_SER && pins_q.clr_n && cs_rise && xfer_word.dis) |=> ##1 (switch_on_o == `AMX_SW_OFF)
  ) else $error("serial disable bit left a switch closed");

  a_dout_stage: assert property (
    @(posedge sclk_i) disable iff (link_clr)
    shift_en |=> (serial_out_o == $past(sh_reg[2]))
  ) else $error("serial out not fed from the third stage");

endmodule : amx_ctrl

`default_nettype wire

// [bench/amx_spi_host.sv]
// serial master model that drives the link of the mux control
`timescale 1ns/1ps
`default_nettype none

module amx_spi_host (
  // serial link
  output logic sclk_o,
  output logic cs_n_o,
  output logic din_o
);
  // link clock stands still outside frames
  initial begin
    sclk_o = 1'h0;
    cs_n_o = 1'h1;
    din_o = 1'h1;
  end

  // one bit a clock, lsb first
  task automatic shift(input logic [3:0] w);
    cs_n_o = 1'h0;
    for (int i = 0; i < 4; i++) begin
      #4 din_o = w[i];
      #3.5 sclk_o = 1'h1;
      #7.5 sclk_o = 1'h0;
    end
  endtask : shift

  task automatic done();
    #5 cs_n_o = 1'h1;
    // released data line shows the inverse of the last bit
    din_o = ~din_o;
  endtask : done
endmodule : amx_spi_host

`default_nettype wire

// [bench/tb_amx_ctrl.sv]
// self-checking testbench of the analog mux switch control
`timescale 1ns/1ps
`default_nettype none

module tb_amx_ctrl;
  logic clk_i, rst_i, ser, clr_n, pair, le_n, bank, hi, lo, en;
  logic sclk, cs_n, din, sout, oe_n;
  logic [7:0] sw, prev;
  logic [31:0] seed, r;
  logic [4:0] v;
  logic [3:0] w;
  int num_errors, tests_run;

  amx_spi_host host_u (.sclk_o(sclk), .cs_n_o(cs_n), .din_o(din));

  amx_ctrl dut_u (
    .clk_i(clk_i), .rst_i(rst_i), .sclk_i(sclk), .cs_n_i(cs_n), .serial_in_i(din),
    .serial_out_o(sout), .serial_out_oe_n_o(oe_n), .serial_parallel_select_i(ser),
    .clear_all_n_i(clr_n), .dual_pair_select_i(pair), .latch_open_n_i(le_n),
    .bank_select_bit_i(bank), .channel_addr_hi_i(hi), .channel_addr_lo_i(lo),
    .enable_i(en), .switch_on_o(sw)
  );

  always #10 clk_i = ~clk_i;

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd

  function automatic logic [7:0] expect_sw(input logic dis, input logic pr, input logic [2:0] a);
    if (dis) return 8'h00;
    if (pr) return 8'h11 << a[1:0];
    return 8'h01 << a;
  endfunction : expect_sw

  task automatic chk_sw(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_sw

  task automatic chk_bit(input logic got, input logic exp);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_bit

  task automatic wait_clk(input int n);
    repeat (n) @(negedge clk_i);
  endtask : wait_clk

  task automatic test_done();
    $display("errors=%0d tests=%0d", num_errors, tests_run);
    if (num_errors == 0 && tests_run > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : test_done

  initial begin
    #50000;
    num_errors++;
    test_done();
  end

  initial begin
    clk_i = 1'h0;
    rst_i = 1'h1;
    seed = 32'h5917;
    {ser, clr_n, pair, le_n, bank, hi, lo, en} = 8'h50;
    num_errors = 0;
    tests_run = 0;
    wait_clk(3);
    rst_i = 1'h0;
    wait_clk(4);
    chk_sw(sw, 8'h00);
    chk_bit(oe_n, 1'h1);
    // every decode code first, then random words
    for (int i = 0; i < 24; i++) begin
      r = rnd();
      v = (i < 16) ? {i[3], 1'h1, i[2:0]} : r[4:0];
      {pair, en, bank, hi, lo} = v;
      le_n = 1'h0;
      wait_clk(6);
      chk_sw(sw, expect_sw(!en, pair, {bank, hi, lo}));
    end
    {pair, en, bank, hi, lo} = 5'h0D;
    wait_clk(6);
    le_n = 1'h1;
    wait_clk(4);
    {en, bank, hi, lo} = 4'h2;
    wait_clk(6);
    chk_sw(sw, 8'h20);
    pair = 1'h1;
    wait_clk(6);
    chk_sw(sw, 8'h22);
    clr_n = 1'h0;
    wait_clk(6);
    chk_sw(sw, 8'h00);
    clr_n = 1'h1;
    wait_clk(4);
    ser = 1'h1;
    le_n = 1'h0;
    {en, bank, hi, lo} = 4'hF;
    wait_clk(6);
    chk_sw(sw, 8'h00);
    chk_bit(oe_n, 1'h0);
    // warm-up bits let the link side see serial mode first
    host_u.shift(4'h0);
    // word still latched: the cleared one, disabled
    w = 4'h8;
    for (int i = 0; i < 10; i++) begin
      r = rnd();
      pair = r[4];
      // pair select is live, so the held word decodes with the new pin
      prev = expect_sw(w[3], pair, w[2:0]);
      w = (i == 0) ? 4'h7 : (i == 1) ? 4'h8 : r[3:0];
      host_u.shift(w);
      wait_clk(6);
      chk_sw(sw, prev);
      chk_bit(sout, w[0]);
      host_u.done();
      wait_clk(6);
      chk_sw(sw, expect_sw(w[3], pair, w[2:0]));
    end
    host_u.shift(4'hF);
    clr_n = 1'h0;
    wait_clk(6);
    chk_sw(sw, 8'h00);
    chk_bit(sout, 1'h0);
    clr_n = 1'h1;
    wait_clk(4);
    host_u.done();
    wait_clk(6);
    chk_sw(sw, expect_sw(1'h0, pair, 3'h0));
    // back to parallel: open latch takes the enabled word on the pins
    ser = 1'h0;
    wait_clk(6);
    chk_bit(oe_n, 1'h1);
    chk_sw(sw, expect_sw(1'h0, pair, 3'h7));
    test_done();
  end
endmodule : tb_amx_ctrl

`default_nettype wire
